// ===== rtl/adc_serial_control_pins.sv
/*
  Top of the converter control block: pin synchronisers, register file,
  conversion and calibration engine, data-ready and shared digital pins.
  Assumes a master clock on core_clk_i, a modulator bit stream on the same
  clock, and a host that drives the serial clock, chip select and data in.
*/
`timescale 1ns/100ps
module adc_serial_control_pins
  import adc_ctrl_pkg::*;
#(
  parameter int UPDATE_CYCLES = UPD_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic clock_polarity_sel_i,
  input wire logic sync_n_i,
  input wire logic reset_n_i,
  input wire logic standby_n_i,
  input wire logic mod_bit_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic rdy_o,
  output logic clock_out_o,
  output logic shared_input3_out1_o,
  output logic shared_input3_out1_oe_o,
  output logic shared_input4_out0_o,
  output logic shared_input4_out0_oe_o,
  output logic high_reference_sel_o,
  output logic modulator_reset_o,
  output logic circuit_halt_o
);
  serial_regs_if rif ();

  logic [4:0] sync_out;
  logic sync_n_s, reset_n_s, stdby_n_s, wr_tgl_s, rd_tgl_s;
  logic int_rst, wr_tgl_q, rd_tgl_q, wr_pulse, rd_pulse;
  logic wr_en, wr_mode, upd_done, cal_done, upd_last;
  logic [MODE_W-1:0] mode, filt, next_mode;
  logic [WORD_W-1:0] data, offs, gain, result;
  logic [2:0] op;
  logic op_conv, op_cal;
  logic [3:0] dec_exp;
  logic [CNT_W-1:0] dec_mask, cnt, next_cnt;
  logic [CNT_W:0] ones, next_ones;
  logic [WORD_W+CNT_W:0] scaled_wide;
  logic rdy, next_rdy, mod_rst;
  eng_t state, next_state;

  if (UPDATE_CYCLES < 2 || UPDATE_CYCLES > 255) begin : g_chk
    $error("UPDATE_CYCLES must lie in 2..255");
  end

  // Sync, reset and standby pin levels and link toggles all cross through two flops
  bit_sync #(
    .WIDTH(5),
    .RST_VAL(5'h1c)
  ) u_sync (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i({sync_n_i, reset_n_i, standby_n_i, rif.wr_tgl, rif.rd_tgl}),
    .sync_o(sync_out)
  );
  assign {sync_n_s, reset_n_s, stdby_n_s, wr_tgl_s, rd_tgl_s} = sync_out;

  // Serial shift logic on the host clock
  serial_shifter u_shift (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .clock_polarity_sel_i(clock_polarity_sel_i),
    .dout_o(dout_o),
    .dout_oe_o(dout_oe_o),
    .lnk(rif.link)
  );

  // Reset pin resets the engine, register file and serial link
  assign int_rst = rst_i | ~reset_n_s;

  // Toggle edges mark finished serial words; the word itself has been
  // steady for two core cycles by the time the pulse is seen
  assign wr_pulse = wr_tgl_s ^ wr_tgl_q;
  assign rd_pulse = rd_tgl_s ^ rd_tgl_q;
  // Standby halts the digital side, so writes seen then are dropped
  assign wr_en = wr_pulse & stdby_n_s;
  assign wr_mode = wr_en & (rif.wr_sel == SEL_MODE);

  // Mode field decode
  assign op = mode[MODE_OP_MSB:MODE_OP_LSB];
  assign op_conv = (op == OP_CONV);
  assign op_cal = (op == OP_ZCAL) | (op == OP_FCAL);

  // Decimation length is a power of two taken from the filter word
  assign dec_exp = (filt[FILT_EXP_MSB:FILT_EXP_LSB] < FILT_EXP_MIN) ?
    FILT_EXP_MIN : filt[FILT_EXP_MSB:FILT_EXP_LSB];
  assign dec_mask = ~({CNT_W{1'b1}} << dec_exp);

  // Ones count scaled to the full code range; a full count saturates
  // to all ones, so the bottom is all zeros and midscale is 800000
  assign scaled_wide = {{WORD_W{1'b0}}, ones} <<
    (5'(WORD_W) - {1'b0, dec_exp});
  assign result = (|scaled_wide[WORD_W+CNT_W:WORD_W]) ? FULL_CODE :
    scaled_wide[WORD_W-1:0];

  // Engine events that touch the register file
  assign upd_last = (cnt == CNT_W'(UPDATE_CYCLES - 1));
  assign upd_done = stdby_n_s & sync_n_s & ~wr_mode &
    (state == ST_UPD) & upd_last;
  assign cal_done = stdby_n_s & sync_n_s & ~wr_mode & (state == ST_CAL);

  // A host write of the mode word wins over the end-of-calibration clear
  assign next_mode = wr_mode ? rif.wr_word[MODE_W-1:0] :
    cal_done ? {OP_IDLE, mode[MODE_OP_LSB-1:0]} : mode;

  // Engine next state
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ones = ones;
    next_rdy = rdy;
    if (!stdby_n_s) begin
      next_state = state;
    end else if (!sync_n_s || wr_mode) begin
      // Sync clears filter and sequencers; a mode write restarts them
      next_state = ST_IDLE;
      next_cnt = '0;
      next_ones = '0;
      if (!sync_n_s) begin
        next_rdy = 1'b1;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          // Programmed operation begins once sync is released
          if (op_conv || op_cal) begin
            next_state = ST_ACQ;
            next_cnt = '0;
            next_ones = '0;
          end
          if (op_cal) begin
            next_rdy = 1'b1;
          end
        end
        ST_ACQ: begin
          next_ones = ones + {{CNT_W{1'b0}}, mod_bit_i};
          next_cnt = cnt + CNT_W'(1);
          // A complete data read raises data-ready; a second read of
          // the same word is harmless
          if (op_conv && rd_pulse) begin
            next_rdy = 1'b1;
          end
          if (cnt == dec_mask) begin
            next_cnt = '0;
            next_state = op_cal ? ST_CAL : ST_UPD;
            if (!op_cal) begin
              next_rdy = 1'b1;
            end
          end
        end
        ST_UPD: begin
          // Data-ready stays high for the whole update window
          next_rdy = 1'b1;
          next_cnt = cnt + CNT_W'(1);
          if (upd_last) begin
            next_state = ST_ACQ;
            next_cnt = '0;
            next_ones = '0;
            next_rdy = 1'b0;
          end
        end
        ST_CAL: begin
          next_state = ST_IDLE;
          next_ones = '0;
          next_rdy = 1'b0;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge core_clk_i) begin
    if (int_rst) begin
      state <= ST_IDLE;
      cnt <= '0;
      ones <= '0;
      rdy <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ones <= next_ones;
      rdy <= next_rdy;
    end
  end

  // Toggle followers track the synchroniser during reset so that no
  // stale edge is taken as a word once reset lifts
  always_ff @(posedge core_clk_i) begin
    wr_tgl_q <= wr_tgl_s;
    rd_tgl_q <= rd_tgl_s;
  end

  // Register file; standby leaves every word untouched
  always_ff @(posedge core_clk_i) begin
    if (int_rst) begin
      mode <= MODE_RST;
      filt <= FILT_RST;
      data <= DATA_RST;
      offs <= OFFS_RST;
      gain <= GAIN_RST;
    end else begin
      mode <= next_mode;
      if (wr_en && rif.wr_sel == SEL_FILTER) begin
        filt <= rif.wr_word[MODE_W-1:0];
      end
      if (upd_done) begin
        data <= result;
      end
      if (wr_en && rif.wr_sel == SEL_OFFS) begin
        offs <= rif.wr_word;
      end else if (cal_done && op == OP_ZCAL) begin
        offs <= result;
      end
      if (wr_en && rif.wr_sel == SEL_GAIN) begin
        gain <= rif.wr_word;
      end else if (cal_done && op == OP_FCAL) begin
        gain <= result;
      end
    end
  end

  // Link reset comes from a flop so the far domain sees a clean level
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rif.link_rst <= 1'b1;
      mod_rst <= 1'b1;
    end else begin
      rif.link_rst <= int_rst;
      mod_rst <= int_rst | ~sync_n_s | ~stdby_n_s;
    end
  end

  // Words offered to the shift register, zero-extended to 24 bits
  assign rif.data_word = data;
  assign rif.mode_word = {{(WORD_W-MODE_W){1'b0}}, mode};
  assign rif.filt_word = {{(WORD_W-MODE_W){1'b0}}, filt};
  assign rif.offs_word = offs;
  assign rif.gain_word = gain;
  assign rif.stat_word = {{(WORD_W-STAT_W){1'b0}}, rdy,
    (state == ST_CAL) | op_cal, ~sync_n_s, ~stdby_n_s, 1'b0, op};

  // Pin outputs
  assign rdy_o = rdy;
  // Inverted copy only; it carries no duty-cycle correction
  assign clock_out_o = ~core_clk_i;
  assign shared_input3_out1_oe_o = mode[MODE_DEN];
  assign shared_input3_out1_o = mode[MODE_D1];
  assign shared_input4_out0_oe_o = mode[MODE_DEN];
  assign shared_input4_out0_o = mode[MODE_D0];
  // Reference range steers the analog scaling
  assign high_reference_sel_o = mode[MODE_HIGH_REFERENCE_SEL];
  assign modulator_reset_o = mod_rst;
  assign circuit_halt_o = ~stdby_n_s;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (int_rst);

  property p_sync_rdy;
    !sync_n_s |=> rdy;
  endproperty
  a_sync_rdy: assert property (p_sync_rdy)
    else $error("data-ready not high under sync");

  property p_sync_clear;
    !sync_n_s && stdby_n_s |=> state == ST_IDLE && ones == '0 &&
      modulator_reset_o;
  endproperty
  a_sync_clear: assert property (p_sync_clear)
    else $error("sync did not clear the engine");

  property p_read_rdy;
    stdby_n_s && sync_n_s && !wr_mode && op_conv && rd_pulse &&
      state == ST_ACQ |=> rdy;
  endproperty
  a_read_rdy: assert property (p_read_rdy)
    else $error("data-ready not raised by a full read");

  property p_upd_window;
    $rose(state == ST_UPD) |-> rdy [*2];
  endproperty
  a_upd_window: assert property (p_upd_window)
    else $error("data-ready low inside the update");

  property p_upd_end;
    upd_done |=> !rdy && data == $past(result);
  endproperty
  a_upd_end: assert property (p_upd_end)
    else $error("update did not end with fresh data and ready low");

  property p_cal_start;
    state == ST_IDLE && op_cal && stdby_n_s && sync_n_s && !wr_mode
      |=> rdy && state == ST_ACQ;
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration start did not raise data-ready");

  property p_cal_end;
    cal_done |=> !rdy && op == OP_IDLE;
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("calibration end did not drop data-ready");

  property p_standby_hold;
    !stdby_n_s |=> $stable(state) && $stable(mode) && $stable(data) &&
      $stable(rdy);
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("state moved during standby");

  property p_dig_out;
    wr_mode && rif.wr_word[MODE_DEN] |=> shared_input3_out1_oe_o &&
      shared_input3_out1_o == $past(rif.wr_word[MODE_D1]) &&
      shared_input4_out0_o == $past(rif.wr_word[MODE_D0]);
  endproperty
  a_dig_out: assert property (p_dig_out)
    else $error("shared pins do not follow the mode write");

  property p_high_reference_sel;
    wr_mode |=> high_reference_sel_o == $past(rif.wr_word[MODE_HIGH_REFERENCE_SEL]);
  endproperty
  a_high_reference_sel: assert property (p_high_reference_sel)
    else $error("reference range not taken from mode write");

  property p_reset;
    disable iff (rst_i) !reset_n_s |=> mode == MODE_RST && rdy &&
      state == ST_IDLE;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset pin did not restore power-on values");
endmodule

// ===== rtl/adc_ctrl_pkg.sv
/*
  Shared constants for the converter serial control block: serial register
  selects, word widths, register fields, reset values and engine states.
  Assumes that every file using it imports the whole package.
*/
package adc_ctrl_pkg;
  localparam int WORD_W = 24;
  localparam int MODE_W = 16;
  localparam int STAT_W = 8;
  localparam int CMD_W = 8;
  localparam int CNT_W = 16;
  localparam int CMD_RD_BIT = 6;
  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_DATA = 3'h1;
  localparam logic [2:0] SEL_MODE = 3'h2;
  localparam logic [2:0] SEL_FILTER = 3'h3;
  localparam logic [2:0] SEL_OFFS = 3'h4;
  localparam logic [2:0] SEL_GAIN = 3'h5;
  localparam int MODE_OP_MSB = 15;
  localparam int MODE_OP_LSB = 13;
  localparam int MODE_HIGH_REFERENCE_SEL = 7;
  localparam int MODE_DEN = 6;
  localparam int MODE_D1 = 5;
  localparam int MODE_D0 = 4;
  localparam int FILT_EXP_MSB = 3;
  localparam int FILT_EXP_LSB = 0;
  localparam logic [3:0] FILT_EXP_MIN = 4'h4;
  localparam logic [2:0] OP_IDLE = 3'h0;
  localparam logic [2:0] OP_CONV = 3'h1;
  localparam logic [2:0] OP_ZCAL = 3'h4;
  localparam logic [2:0] OP_FCAL = 3'h5;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] FILT_RST = 16'h0008;
  localparam logic [23:0] DATA_RST = 24'h000000;
  localparam logic [23:0] OFFS_RST = 24'h800000;
  localparam logic [23:0] GAIN_RST = 24'h400000;
  localparam logic [23:0] FULL_CODE = 24'hffffff;
  localparam int UPD_CYC = 3;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACQ = 4'b0010,
    ST_UPD = 4'b0100,
    ST_CAL = 4'b1000
  } eng_t;
  // Serial word length of each register
  function automatic logic [4:0] word_len(input logic [2:0] sel);
    case (sel)
      SEL_STATUS: word_len = 5'(STAT_W);
      SEL_MODE, SEL_FILTER: word_len = 5'(MODE_W);
      default: word_len = 5'(WORD_W);
    endcase
  endfunction
endpackage

// ===== rtl/serial_regs_if.sv
/*
  Carrier between the core engine and the serial shifter.
  Assumes the core side owns register contents and the link side the words.
*/
`timescale 1ns/100ps
interface serial_regs_if;
  logic [23:0] data_word;
  logic [23:0] mode_word;
  logic [23:0] filt_word;
  logic [23:0] stat_word;
  logic [23:0] offs_word;
  logic [23:0] gain_word;
  logic [23:0] wr_word;
  logic [2:0] wr_sel;
  logic wr_tgl;
  logic rd_tgl;
  logic link_rst;
  modport core (output data_word, mode_word, filt_word, stat_word,
    offs_word, gain_word, link_rst, input wr_word, wr_sel, wr_tgl, rd_tgl);
  modport link (input data_word, mode_word, filt_word, stat_word,
    offs_word, gain_word, link_rst, output wr_word, wr_sel, wr_tgl, rd_tgl);
endinterface

// ===== rtl/bit_sync.sv
/*
  Two-stage synchroniser for a group of independent levels.
  Assumes each bit is a level or a toggle; no bus crosses here.
*/
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;
  if (WIDTH < 1) begin : g_chk
    $error("bit_sync needs at least one bit");
  end
  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// ===== rtl/serial_shifter.sv
/*
  Serial port shift logic, clocked by the host serial clock.
  Assumes polarity is strapped and the core keeps register words steady.
*/
`timescale 1ns/100ps
module serial_shifter
  import adc_ctrl_pkg::*;
(
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic clock_polarity_sel_i,
  output logic dout_o,
  output logic dout_oe_o,
  serial_regs_if.link lnk
);
  logic samp_clk, frame_rst, data_phase, rd_cmd;
  logic [4:0] bitcnt, len;
  logic [2:0] sel;
  logic [WORD_W-1:0] in_sr, out_sr, rd_word;
  logic [CMD_W-1:0] cmd_byte;
  logic cmd_end, word_end;

  // Rising edge of this clock is the sample edge for either polarity
  assign samp_clk = sclk_i ^ ~clock_polarity_sel_i;
  // Deselect aborts a frame; three-wire use simply never deselects
  assign frame_rst = lnk.link_rst | cs_n_i;
  assign len = word_len(sel);
  assign cmd_byte = {in_sr[CMD_W-2:0], din_i};
  assign cmd_end = ~data_phase & (bitcnt == 5'(CMD_W - 1));
  assign word_end = data_phase & (bitcnt == len - 5'h1);
  // The data word changes only outside a data-ready low window
  assign rd_word = (sel == SEL_DATA) ? lnk.data_word :
    (sel == SEL_MODE) ? lnk.mode_word :
    (sel == SEL_FILTER) ? lnk.filt_word :
    (sel == SEL_OFFS) ? lnk.offs_word :
    (sel == SEL_GAIN) ? lnk.gain_word : lnk.stat_word;
  assign dout_o = out_sr[WORD_W-1];
  assign dout_oe_o = ~cs_n_i & data_phase & rd_cmd;

  // Frame position; state holds while a gapped clock is parked
  always_ff @(posedge samp_clk or posedge frame_rst) begin
    if (frame_rst) begin
      bitcnt <= '0;
      data_phase <= 1'b0;
      in_sr <= '0;
    end else begin
      in_sr <= {in_sr[WORD_W-2:0], din_i};
      bitcnt <= (cmd_end | word_end) ? 5'h0 : bitcnt + 5'h1;
      data_phase <= cmd_end | (data_phase & ~word_end);
    end
  end

  // Command register and word hand-off, cleared only by the core reset
  always_ff @(posedge samp_clk or posedge lnk.link_rst) begin
    if (lnk.link_rst) begin
      sel <= SEL_STATUS;
      rd_cmd <= 1'b0;
      lnk.wr_word <= '0;
      lnk.wr_sel <= SEL_STATUS;
      lnk.wr_tgl <= 1'b0;
      lnk.rd_tgl <= 1'b0;
    end else if (cmd_end) begin
      sel <= cmd_byte[2:0];
      rd_cmd <= cmd_byte[CMD_RD_BIT];
    end else if (word_end & ~rd_cmd) begin
      lnk.wr_word <= {in_sr[WORD_W-2:0], din_i};
      lnk.wr_sel <= sel;
      lnk.wr_tgl <= ~lnk.wr_tgl;
    end else if (word_end & (sel == SEL_DATA)) begin
      lnk.rd_tgl <= ~lnk.rd_tgl;
    end
  end

  // Launch edge: load MSB-aligned word on the first data bit, else shift
  always_ff @(negedge samp_clk or posedge frame_rst) begin
    if (frame_rst) begin
      out_sr <= '0;
    end else if (data_phase & (bitcnt == 5'h0)) begin
      out_sr <= rd_word << (5'(WORD_W) - len);
    end else begin
      out_sr <= {out_sr[WORD_W-2:0], 1'b0};
    end
  end
endmodule

// ===== verification/serial_host_model.sv
/*
  Host serial port model: frames one burst of clock, select and data in.
  Assumes the bench calls frame() and keeps the polarity strap steady.
*/
`timescale 1ns/100ps
module serial_host_model (
  input wire logic pol_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // One framed burst, MSB first; the clock stands still between bursts
  task automatic frame(input logic [31:0] bits, input int n,
                       output logic [31:0] rd);
    rd = '0;
    #13 sclk_o = pol_i;
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = bits[i];
      #40 sclk_o = ~pol_i;
      #80 sclk_o = pol_i;
      rd = {rd[30:0], dout_i};
      #40;
    end
    cs_n_o = 1'b1;
    din_o = ~din_o; // Released line must not keep the last level
  endtask
endmodule

// ===== verification/adc_serial_control_pins_tb.sv
/*
  Self-checking bench for the converter serial control block.
  Assumes the host model is compiled first and drives the serial pins.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module adc_serial_control_pins_tb;
  import adc_ctrl_pkg::*;
  localparam int UPD = 4;
  logic clk, rst, clock_polarity_sel, sync_n, reset_n, standby_n, mod_bit;
  logic sclk, cs_n, din, dout, dout_oe, rdy, clk_out, high_reference_sel, mod_rst, halt;
  logic o3, o3_oe, o4, o4_oe;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int k;
  logic [31:0] rv;
  logic [15:0] modes [3] = '{16'h00f0, 16'h0060, 16'h0010};
  adc_serial_control_pins #(.UPDATE_CYCLES(UPD)) dut_u (.core_clk_i(clk),
    .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .clock_polarity_sel_i(clock_polarity_sel), .sync_n_i(sync_n), .reset_n_i(reset_n),
    .standby_n_i(standby_n), .mod_bit_i(mod_bit), .dout_o(dout),
    .dout_oe_o(dout_oe), .rdy_o(rdy), .clock_out_o(clk_out),
    .shared_input3_out1_o(o3), .shared_input3_out1_oe_o(o3_oe),
    .shared_input4_out0_o(o4), .shared_input4_out0_oe_o(o4_oe),
    .high_reference_sel_o(high_reference_sel), .modulator_reset_o(mod_rst),
    .circuit_halt_o(halt));
  serial_host_model host (.pol_i(clock_polarity_sel), .dout_i(dout), .sclk_o(sclk),
    .cs_n_o(cs_n), .din_o(din));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Modulator stream alternates, so each decimation counts half ones and data reads midscale
  always @(negedge clk) mod_bit <= ~mod_bit;
  // Hang guard, well above the expected run of some 4200 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // One command byte then n data bits; returns the data bits read
  task automatic xfer(input logic r, input logic [2:0] sel, input int n,
                      input logic [23:0] d, output logic [23:0] q);
    logic [31:0] b;
    b = ({1'b0, r, 3'h0, sel, 24'h0} >> (24 - n)) | 32'(d);
    host.frame(b, n + 8, rv);
    q = rv[23:0] & ~(24'hffffff << n);
    @(negedge clk);
    `CHK("dout_oe idle", 1'b0, dout_oe)
  endtask
  task automatic rdchk(input string nm, input logic [2:0] sel, input int n,
                       input logic [23:0] e);
    logic [23:0] q;
    xfer(1'b1, sel, n, 24'h0, q);
    `CHK(nm, e, q)
  endtask
  task automatic wr(input logic [2:0] sel, input int n, input logic [23:0] d);
    logic [23:0] q;
    xfer(1'b0, sel, n, d, q);
    repeat (4) @(negedge clk);
  endtask
  // Bounded wait for a data-ready level
  task automatic wait_rdy(input logic lvl);
    k = 0;
    while (rdy !== lvl && k < 3000) begin
      @(negedge clk);
      k++;
    end
    `CHK("rdy wait", lvl, rdy)
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    clock_polarity_sel = 1'b0;
    sync_n = 1'b1;
    reset_n = 1'b1;
    standby_n = 1'b1;
    mod_bit = 1'b0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("rdy", 1'b1, rdy)
    `CHK("oe", 2'h0, {o3_oe, o4_oe})
    `CHK("clk_out", 1'b1, clk_out)
    rdchk("filter", SEL_FILTER, 16, 24'(FILT_RST));
    rdchk("offset", SEL_OFFS, 24, OFFS_RST);
    rdchk("gain", SEL_GAIN, 24, GAIN_RST);
    $display("test reset done");
    // Shared pins and reference select follow each mode word
    foreach (modes[i]) begin
      wr(SEL_MODE, 16, 24'(modes[i]));
      `CHK("oe", {2{modes[i][6]}}, {o3_oe, o4_oe})
      `CHK("pins", modes[i][5:4], {o3, o4})
      `CHK("high_reference_sel", modes[i][7], high_reference_sel)
      rdchk("mode", SEL_MODE, 16, 24'(modes[i]));
    end
    $display("test pins done");
    // Exponent 9 leaves room for two reads between updates
    wr(SEL_FILTER, 16, 24'h000009);
    wr(SEL_MODE, 16, {8'h0, OP_CONV, 13'h0});
    wait_rdy(1'b0);
    rdchk("data", SEL_DATA, 24, 24'h800000);
    repeat (4) @(negedge clk);
    `CHK("rdy read", 1'b1, rdy)
    rdchk("reread", SEL_DATA, 24, 24'h800000);
    wait_rdy(1'b0);
    wait_rdy(1'b1);
    k = 0;
    while (rdy === 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    `CHK("update high", UPD, k)
    $display("test convert done");
    // Sync forces ready high, keeps the port alive, starts the staged op
    sync_n = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("sync rdy", 1'b1, rdy)
    `CHK("sync mod", 1'b1, mod_rst)
    wr(SEL_MODE, 16, {8'h0, OP_ZCAL, 13'h0});
    rdchk("sync mode", SEL_MODE, 16, 24'h008000);
    `CHK("sync hold", 1'b1, rdy)
    sync_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("cal rdy", 1'b1, rdy)
    `CHK("cal mod", 1'b0, mod_rst)
    wait_rdy(1'b0);
    rdchk("cal op", SEL_MODE, 16, 24'h0);
    $display("test sync done");
    // Standby keeps registers; a write there is dropped
    wr(SEL_MODE, 16, 24'h0000c0);
    standby_n = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("halt", 1'b1, halt)
    wr(SEL_MODE, 16, 24'h0);
    rdchk("stby mode", SEL_MODE, 16, 24'h0000c0);
    `CHK("stby pins", 2'h3, {high_reference_sel, o3_oe})
    standby_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("run", 1'b0, halt)
    host.frame(32'h2, 5, rv);
    wr(SEL_MODE, 16, 24'h000040);
    rdchk("after abort", SEL_MODE, 16, 24'h000040);
    $display("test standby done");
    // Reset pin returns everything to power-on values
    reset_n = 1'b0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("pin rst", 4'h1, {high_reference_sel, o3_oe, o4_oe, rdy})
    rdchk("rst mode", SEL_MODE, 16, 24'h0);
    $display("test reset pin done");
    close_out();
  end
endmodule
